// *** design/ecm_channel.sv ***
/*
 * ecm_channel: mode control of one enhanced capture/compare/PWM channel,
 * with its register file on AHB-Lite, capture and compare engines, the
 * PWM timebase with double-buffered duty and the four-output steering.
 * Assumes the two capture/compare timers and the pin input come from
 * outside; the timers are on clk, the pin is asynchronous.
 */
// The implementer's own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
module ecm_channel (
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output logic                    hreadyout,
    output logic [31:0]             hrdata,
    output logic                    hresp,
    input  wire logic               ccp_pin_in,
    input  wire logic [15:0]        capture_timer_a,
    input  wire logic [15:0]        capture_timer_b,
    output ecm_pkg::ecm_pins_t      pwm_out,
    output ecm_pkg::ecm_pins_t      pwm_out_en_n,
    output logic                    timer_reset_a,
    output logic                    timer_reset_b,
    output logic                    adc_start,
    output logic                    channel_irq_flag,
    output logic [4:0]              chan_timer_sel
);
    import ecm_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // register bus
    logic [7:0]  ctrl;
    logic [4:0]  tsel;
    logic [15:0] value;
    logic [7:0]  period;
    logic        tmr_en;
    logic [3:0]  steer;
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic        cmp_pin;
    logic        pwm_lvl;
    logic        pwm_run;

    wire        addr_take = hsel & htrans[1] & hready;
    wire        addr_hit  = (haddr[31:5] == 27'h0) & (haddr[1:0] == 2'b00);
    wire [7:0]  raddr     = haddr[7:0];
    wire        wr_ctrl   = wr_pend & (wr_addr == ADDR_CTRL);
    wire        wr_tsel   = wr_pend & (wr_addr == ADDR_TSEL);
    wire        wr_value  = wr_pend & (wr_addr == ADDR_VALUE);
    wire        wr_period = wr_pend & (wr_addr == ADDR_PERIOD);
    wire        wr_tctrl  = wr_pend & (wr_addr == ADDR_TCTRL);
    wire        wr_status = wr_pend & (wr_addr == ADDR_STATUS);

    wire [31:0] rd_status = {29'h0, pwm_lvl, cmp_pin, channel_irq_flag};
    wire [31:0] rd_mux =
        !addr_hit              ? 32'h0 :
        (raddr == ADDR_CTRL)   ? {24'h0, ctrl} :
        (raddr == ADDR_TSEL)   ? {27'h0, tsel} :
        (raddr == ADDR_VALUE)  ? {16'h0, value} :
        (raddr == ADDR_PERIOD) ? {24'h0, period} :
        (raddr == ADDR_TCTRL)  ? {24'h0, steer, 3'h0, tmr_en} :
        (raddr == ADDR_STATUS) ? rd_status :
        32'h0;

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_pend   <= 1'b0;
            wr_addr   <= 8'h00;
            hrdata    <= 32'h0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            wr_pend   <= addr_take & hwrite & addr_hit;
            wr_addr   <= raddr;
            hrdata    <= (addr_take & !hwrite) ? rd_mux : 32'h0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control fields
    wire [3:0] mode   = ctrl[CTRL_MODE_LSB +: 4];
    wire [1:0] frac   = ctrl[CTRL_FRAC_LSB +: 2];
    wire [1:0] ocfg   = ctrl[CTRL_OCFG_LSB +: 2];
    wire       m_pwm  = ecm_is_pwm(mode);
    wire       m_cap  = ecm_is_cap(mode);
    wire       m_cmp  = ecm_is_cmp(mode);
    wire [3:0] n_mode = hwdata[CTRL_MODE_LSB +: 4];

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl   <= RST_CTRL;
            tsel   <= RST_TSEL;
            period <= RST_PERIOD;
            tmr_en <= 1'b0;
            steer  <= RST_STEER;
        end else begin
            if (wr_ctrl)
                ctrl <= hwdata[7:0];
            if (wr_tsel)
                tsel <= hwdata[4:0];
            if (wr_period)
                period <= hwdata[7:0];
            if (wr_tctrl) begin
                tmr_en <= hwdata[TCTRL_EN_BIT];
                steer  <= hwdata[TCTRL_STR_LSB +: 4];
            end
        end
    end

    // bit n routes channel n+1 to timer pair 3/4 when set
    always_ff @(posedge clk) begin
        if (rst)
            chan_timer_sel <= RST_TSEL;
        else
            chan_timer_sel <= tsel;
    end

    ////////////////////////////////////////////////////////////////////////
    // pin input: three stages, a change counts when stages two and three agree
    logic s1;
    logic s2;
    logic s3;
    logic pin_lvl;
    logic [3:0] pre_cnt;

    always_ff @(posedge clk) begin
        if (rst) begin
            s1      <= 1'b0;
            s2      <= 1'b0;
            s3      <= 1'b0;
            pin_lvl <= 1'b0;
        end else begin
            s1 <= ccp_pin_in;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3)
                pin_lvl <= s3;
        end
    end

    wire pin_rise = (s2 == s3) & s3 & !pin_lvl;
    wire pin_fall = (s2 == s3) & !s3 & pin_lvl;

    ////////////////////////////////////////////////////////////////////////
    // capture
    wire [15:0] cc_time = tsel[0] ? capture_timer_b : capture_timer_a;
    wire pre_mode = (mode == MODE_CAP_R4) | (mode == MODE_CAP_R16);
    wire pre_last = (mode == MODE_CAP_R4) ? (pre_cnt == PRE_DIV4)
                                          : (pre_cnt == PRE_DIV16);
    wire cap_evt  =
        !m_cap                  ? 1'b0 :
        (mode == MODE_CAP_FALL) ? pin_fall :
        (mode == MODE_CAP_RISE) ? pin_rise :
        pre_mode                ? pin_rise & pre_last :
        pin_rise | pin_fall;

    // prescaler is cleared whenever neither prescaled capture mode (every 4th or every 16th rise) is selected
    always_ff @(posedge clk) begin
        if (rst)
            pre_cnt <= 4'h0;
        else if (!m_cap || !pre_mode)
            pre_cnt <= 4'h0;
        else if (pin_rise)
            pre_cnt <= pre_last ? 4'h0 : pre_cnt + 4'h1;
    end

    ////////////////////////////////////////////////////////////////////////
    // compare
    logic match_q;
    wire  match   = m_cmp & (cc_time == value);
    wire  cmp_evt = match & !match_q;
    wire  spev    = cmp_evt & (mode == MODE_CMP_SPEV);

    always_ff @(posedge clk) begin
        if (rst)
            match_q <= 1'b0;
        else
            match_q <= match;
    end

    // compare output latch, preset by the mode write
    always_ff @(posedge clk) begin
        if (rst)
            cmp_pin <= 1'b0;
        else if (wr_ctrl && n_mode == MODE_CMP_SET)
            cmp_pin <= 1'b0;
        else if (wr_ctrl && n_mode == MODE_CMP_CLR)
            cmp_pin <= 1'b1;
        else if (mode == MODE_OFF)
            cmp_pin <= 1'b0;
        else if (cmp_evt && mode == MODE_CMP_TGL)
            cmp_pin <= !cmp_pin;
        else if (cmp_evt && mode == MODE_CMP_SET)
            cmp_pin <= 1'b1;
        else if (cmp_evt && mode == MODE_CMP_CLR)
            cmp_pin <= 1'b0;
    end

    // event flag: a new event wins over a software clear
    wire irq_set = cap_evt | cmp_evt;
    wire irq_clr = wr_status & hwdata[STAT_IRQ_BIT];

    always_ff @(posedge clk) begin
        if (rst)
            channel_irq_flag <= 1'b0;
        else
            channel_irq_flag <= irq_set | (channel_irq_flag & !irq_clr);
    end

    // special event: one clock to the selected timer and the converter
    always_ff @(posedge clk) begin
        if (rst) begin
            timer_reset_a <= 1'b0;
            timer_reset_b <= 1'b0;
            adc_start     <= 1'b0;
        end else begin
            timer_reset_a <= spev & !tsel[0];
            timer_reset_b <= spev & tsel[0];
            adc_start     <= spev;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pwm timebase: 8-bit count extended by two sub-count bits
    logic [7:0] tmr;
    logic [1:0] sub;
    logic [1:0] duty_lsb;

    wire [9:0] tmr_ext  = {tmr, sub};
    // count of the next cycle: the level must be low once the count equals the duty
    wire [9:0] tmr_next = tmr_ext + 10'h001;
    wire [9:0] duty_buf = {value[7:0], frac};
    wire [9:0] duty_act = {value[15:8], duty_lsb};
    wire       roll     = tmr_en & (sub == 2'b11) & (tmr == period);

    always_ff @(posedge clk) begin
        if (rst) begin
            tmr <= 8'h00;
            sub <= 2'b00;
        end else if (roll) begin
            tmr <= 8'h00;
            sub <= 2'b00;
        end else if (tmr_en) begin
            {tmr, sub} <= tmr_next;
        end
    end

    // the wave starts only at the first period boundary after entry
    always_ff @(posedge clk) begin
        if (rst) begin
            pwm_run  <= 1'b0;
            pwm_lvl  <= 1'b0;
            duty_lsb <= 2'b00;
        end else if (!m_pwm) begin
            pwm_run  <= 1'b0;
            pwm_lvl  <= 1'b0;
        end else if (roll) begin
            pwm_run  <= 1'b1;
            pwm_lvl  <= (duty_buf != 10'h000);
            duty_lsb <= frac;
        end else if (tmr_en && tmr_next == duty_act) begin
            pwm_lvl  <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // shared 16-bit register: capture value, compare value or duty pair
    wire       pwm_load = m_pwm & roll;
    wire [7:0] next_value_lo =
        cap_evt  ? cc_time[7:0] :
        wr_value ? hwdata[7:0] :
        value[7:0];
    wire [7:0] next_value_hi =
        cap_evt             ? cc_time[15:8] :
        pwm_load            ? value[7:0] :
        (wr_value & !m_pwm) ? hwdata[15:8] :
        value[15:8];

    always_ff @(posedge clk) begin
        if (rst)
            value <= RST_VALUE;
        else
            value <= {next_value_hi, next_value_lo};
    end

    ////////////////////////////////////////////////////////////////////////
    // output steering
    ecm_pins_t next_out;
    ecm_pins_t next_en_n;
    wire       pa = pwm_lvl & pwm_run;
    wire       drive_cmp = (mode == MODE_CMP_TGL) | (mode == MODE_CMP_SET)
                         | (mode == MODE_CMP_CLR);

    always_comb begin
        next_out  = '0;
        next_en_n = '1;
        if (m_pwm) begin
            case (ocfg)
                OCFG_SINGLE: begin
                    next_out  = {4{pa}};
                    next_en_n = ~steer;
                end
                OCFG_FWD: begin
                    next_out  = {1'b1, 1'b0, 1'b0, pa};
                    next_en_n = 4'h0;
                end
                OCFG_HALF: begin
                    next_out  = {pa, !pa, 1'b0, 1'b0};
                    next_en_n = 4'h3;
                end
                OCFG_REV: begin
                    next_out  = {1'b0, pa, 1'b1, 1'b0};
                    next_en_n = 4'h0;
                end
                default: begin
                    next_out  = '0;
                    next_en_n = '1;
                end
            endcase
            next_out.a = next_out.a ^ mode[1];
            next_out.c = next_out.c ^ mode[1];
            next_out.b = next_out.b ^ mode[0];
            next_out.d = next_out.d ^ mode[0];
        end else if (drive_cmp) begin
            next_out.a   = cmp_pin;
            next_en_n.a  = 1'b0;
        end
        // off, reserved, capture and the two flag-only compare modes
        // leave every pin to the port
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pwm_out      <= '0;
            pwm_out_en_n <= '1;
        end else begin
            pwm_out      <= next_out;
            pwm_out_en_n <= next_en_n;
        end
    end

endmodule // ecm_channel

// *** design/ecm_pkg.sv ***
/*
 * ecm_pkg: constants, mode codes, pin carrier and decode helpers for the
 * enhanced capture/compare/PWM channel mode-control block.
 * Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
 */
package ecm_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_TSEL   = 8'h04;
    localparam logic [7:0] ADDR_VALUE  = 8'h08;
    localparam logic [7:0] ADDR_PERIOD = 8'h0C;
    localparam logic [7:0] ADDR_TCTRL  = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;

    // field positions
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_FRAC_LSB = 4;
    localparam int CTRL_OCFG_LSB = 6;
    localparam int TCTRL_EN_BIT  = 0;
    localparam int TCTRL_STR_LSB = 4;
    localparam int STAT_IRQ_BIT  = 0;

    // reset values
    localparam logic [7:0]  RST_CTRL   = 8'h00;
    localparam logic [4:0]  RST_TSEL   = 5'h00;
    localparam logic [15:0] RST_VALUE  = 16'h0000;
    localparam logic [7:0]  RST_PERIOD = 8'hFF;
    localparam logic [3:0]  RST_STEER  = 4'h1;

    // capture prescale terminal counts
    localparam logic [3:0] PRE_DIV4  = 4'h3;
    localparam logic [3:0] PRE_DIV16 = 4'hF;

    typedef enum logic [3:0] {
        MODE_OFF      = 4'h0,
        MODE_RSVD     = 4'h1,
        MODE_CMP_TGL  = 4'h2,
        MODE_CAP_ANY  = 4'h3,
        MODE_CAP_FALL = 4'h4,
        MODE_CAP_RISE = 4'h5,
        MODE_CAP_R4   = 4'h6,
        MODE_CAP_R16  = 4'h7,
        MODE_CMP_SET  = 4'h8,
        MODE_CMP_CLR  = 4'h9,
        MODE_CMP_SWI  = 4'hA,
        MODE_CMP_SPEV = 4'hB
    } ecm_mode_t;

    typedef enum logic [1:0] {
        OCFG_SINGLE = 2'b00,
        OCFG_FWD    = 2'b01,
        OCFG_HALF   = 2'b10,
        OCFG_REV    = 2'b11
    } ecm_ocfg_t;

    typedef struct packed {
        logic a;
        logic b;
        logic c;
        logic d;
    } ecm_pins_t;

    function automatic logic ecm_is_pwm(input logic [3:0] m);
        return m[3] & m[2];
    endfunction

    function automatic logic ecm_is_cap(input logic [3:0] m);
        return (m >= MODE_CAP_ANY) && (m <= MODE_CAP_R16);
    endfunction

    function automatic logic ecm_is_cmp(input logic [3:0] m);
        return (m == MODE_CMP_TGL) || (m[3:2] == 2'b10);
    endfunction

endpackage

// *** test/ecm_bridge_model.sv ***
/*
 * ecm_bridge_model: gate drivers of the power bridge on the four pins.
 * Assumes a weak pull-down on every pin that the channel releases.
 */
`timescale 1ns/1ps
module ecm_bridge_model (
    input wire ecm_pkg::ecm_pins_t pwm_out,
    input wire ecm_pkg::ecm_pins_t pwm_out_en_n,
    output ecm_pkg::ecm_pins_t     gate
);
    import ecm_pkg::*;
    // a released pin falls to the pull-down, never keeps its last level
    assign gate = pwm_out & ~pwm_out_en_n;
endmodule // ecm_bridge_model

// *** test/ecm_channel_asserts.sv ***
/*
 * ecm_channel_asserts: port checker bound into every ecm_channel.
 * Assumes hready is the slave's own hreadyout, so data phases take one cycle.
 */
`timescale 1ns/1ps
module ecm_channel_asserts (
    input wire logic               clk,
    input wire logic               rst,
    input wire logic               hsel,
    input wire logic [31:0]        haddr,
    input wire logic [1:0]         htrans,
    input wire logic               hwrite,
    input wire logic [31:0]        hwdata,
    input wire logic               hready,
    input wire ecm_pkg::ecm_pins_t pwm_out,
    input wire ecm_pkg::ecm_pins_t pwm_out_en_n,
    input wire logic               timer_reset_a,
    input wire logic               timer_reset_b,
    input wire logic               adc_start,
    input wire logic               channel_irq_flag,
    input wire logic [4:0]         chan_timer_sel
);
    import ecm_pkg::*;
    logic       take;
    logic       wr_ctrl;
    logic       wr_stat;
    logic       quiet;
    logic       pwm;
    logic [7:0] ctrl_q;
    logic [4:0] age;

    assign take  = hsel & htrans[1] & hready & hwrite & (haddr[31:8] == 24'h0);
    assign quiet = age == 5'h1F;
    assign pwm   = ctrl_q[3] & ctrl_q[2];

    // shadow of the control register; quiet once it has stood long enough
    // for a new pwm period to have begun
    always_ff @(posedge clk) begin
        wr_ctrl <= !rst & take & (haddr[7:0] == ADDR_CTRL);
        wr_stat <= !rst & take & (haddr[7:0] == ADDR_STATUS);
        ctrl_q  <= rst ? RST_CTRL : (wr_ctrl ? hwdata[7:0] : ctrl_q);
        age     <= (rst | wr_ctrl) ? 5'h00 : age + {4'h0, !quiet};
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence event_s;
        adc_start ##1 !adc_start;
    endsequence
    sequence pwm_cfg_s(logic [1:0] oc);
        quiet && pwm && ctrl_q[7:6] == oc;
    endsequence

    off_pins_a: assert property ((ctrl_q[3:1] == 3'h0)[*3] |-> pwm_out_en_n == 4'hF)
        else $error("pins driven while channel off");
    port_pins_a: assert property (quiet && !pwm |->
        {pwm_out_en_n.b, pwm_out_en_n.c, pwm_out_en_n.d} == 3'h7)
        else $error("spare pins driven outside pwm");
    half_pins_a: assert property (pwm_cfg_s(2'h2) |-> pwm_out_en_n == 4'h3)
        else $error("half bridge pin ownership wrong");
    fwd_pins_a: assert property (pwm_cfg_s(2'h1) |-> pwm_out.a == !ctrl_q[1] &&
        pwm_out.b == ctrl_q[0] && pwm_out.c == ctrl_q[1])
        else $error("forward bridge static pins wrong");
    rev_pins_a: assert property (pwm_cfg_s(2'h3) |-> pwm_out.a == ctrl_q[1] &&
        pwm_out.c == !ctrl_q[1] && pwm_out.d == ctrl_q[0])
        else $error("reverse bridge static pins wrong");
    evt_pulse_a: assert property (adc_start |-> event_s)
        else $error("special event longer than one cycle");
    evt_route_a: assert property (timer_reset_a || timer_reset_b || adc_start |->
        adc_start && timer_reset_b == chan_timer_sel[0] && timer_reset_a != chan_timer_sel[0])
        else $error("special event reset went to wrong timer");
    evt_mode_a: assert property (adc_start |-> $past(ctrl_q[3:0]) == 4'hB)
        else $error("special event outside its mode");
    flag_hold_a: assert property (channel_irq_flag && !(wr_stat && hwdata[0]) |=>
        channel_irq_flag)
        else $error("flag dropped without a clear");
endmodule // ecm_channel_asserts

bind ecm_channel ecm_channel_asserts u_ecm_channel_asserts (
    .clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .pwm_out,
    .pwm_out_en_n, .timer_reset_a, .timer_reset_b, .adc_start, .channel_irq_flag,
    .chan_timer_sel
);

// *** test/tb_enhanced_ccp_mode_control.sv ***
/*
 * tb_enhanced_ccp_mode_control: self-checking bench for ecm_channel.
 * Assumes a zero-wait AHB-Lite slave and 8-bit external timers.
 */
`timescale 1ns/1ps
module tb_enhanced_ccp_mode_control;
    import ecm_pkg::*;
    logic        clk = 1'h0;
    logic        rst = 1'h1;
    logic        hsel = 1'h0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'h0;
    logic [31:0] hwdata = 32'h0;
    logic        hreadyout;
    logic [31:0] hrdata;
    logic        resp;
    logic        pin = 1'h0;
    logic [7:0]  tma = 8'h00;
    logic [7:0]  tmb = 8'h00;
    ecm_pins_t   pout;
    ecm_pins_t   pen_n;
    ecm_pins_t   gate;
    logic        rsa;
    logic        rsb;
    logic        adc;
    logic        flag;
    logic [4:0]  tsel;
    logic [31:0] rd;
    int          n_fail = 0;
    int          check_count = 0;
    int          cyc = 0;
    // control, pin enables, pin mask, expected pins
    logic [19:0] rows [12] = '{20'h00F00, 20'h01F00, 20'hC2700, 20'h08780, 20'h09788,
        20'h0AF00, 20'h4C0E8, 20'h4F0E6, 20'hCC0B2, 20'hCF0B9, 20'h8C300, 20'h0C700};
    logic [39:0] regs [6] = '{40'h0000000000, 40'h0400000000, 40'h0C000000FF,
        40'h1000000010, 40'h0800000000, 40'h1C00000000};
    int          first [5] = '{1, 2, 1, 7, 31};
    int          duty [4] = '{6, 4, 0, 32};

    always #4 clk = ~clk;

    ecm_channel u_ecm_channel (
        .clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hreadyout, .hrdata, .hresp(resp), .ccp_pin_in(pin),
        .capture_timer_a({8'h00, tma}), .capture_timer_b({8'h00, tmb}),
        .pwm_out(pout), .pwm_out_en_n(pen_n), .timer_reset_a(rsa),
        .timer_reset_b(rsb), .adc_start(adc), .channel_irq_flag(flag),
        .chan_timer_sel(tsel)
    );
    ecm_bridge_model u_ecm_bridge_model (.pwm_out(pout), .pwm_out_en_n(pen_n), .gate);

    ////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'h1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr  <= {24'h0, a};
        @(posedge clk);
        while (hreadyout !== 1'h1) @(posedge clk);
        hsel   <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'h1) @(posedge clk);
        rd = hrdata;
    endtask

    task automatic setmode(input logic [7:0] c);
        bus(1'h1, ADDR_CTRL, 32'h0);
        bus(1'h1, ADDR_STATUS, 32'h1);
        bus(1'h1, ADDR_CTRL, {24'h0, c});
    endtask

    task automatic wait_hi(ref logic s);
        int n = 0;
        while (s !== 1'h1 && n < 600) begin
            @(posedge clk);
            n++;
        end
        check("wait bound", 32'(n < 600), 32'h1);
    endtask

    // external timers restart on the channel's special event
    always @(posedge clk) begin
        tma <= (rst | rsa) ? 8'h00 : tma + 8'h01;
        tmb <= (rst | rsb) ? 8'h00 : tmb + 8'h01;
        cyc <= cyc + 1;
        if (cyc == 9000) begin
            n_fail++;
            final_report();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        int n;
        logic a0;
        repeat (12) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        bus(1'h1, ADDR_PERIOD, 32'h3);
        bus(1'h1, ADDR_VALUE, 32'h8000);
        bus(1'h1, ADDR_TCTRL, 32'h81);
        foreach (rows[i]) begin
            bus(1'h1, ADDR_CTRL, 32'(rows[i][19:12]));
            tick(40);
            check("pin enables", 32'(pen_n), 32'(rows[i][11:8]));
            check("bridge pins", 32'(gate & rows[i][7:4]), 32'(rows[i][3:0]));
        end
        // second reset in mid-run
        rst <= 1'h1;
        tick(2);
        rst <= 1'h0;
        tick(1);
        foreach (regs[i]) begin
            bus(1'h0, regs[i][39:32], 32'h0);
            check("reset value", rd, regs[i][31:0]);
            check("bus response", 32'(resp), 32'h0);
        end
        check("released pins", 32'(pen_n), 32'hF);
        bus(1'h1, ADDR_TSEL, 32'hFF);
        bus(1'h1, ADDR_VALUE, 32'h1234A5C3);
        bus(1'h0, ADDR_TSEL, 32'h0);
        check("timer select", rd, 32'h1F);
        check("select pins", 32'(tsel), 32'h1F);
        bus(1'h0, ADDR_VALUE, 32'h0);
        check("value", rd, 32'hA5C3);
        bus(1'h1, ADDR_VALUE, 32'h40);
        for (int s = 0; s < 2; s++) begin
            setmode(8'h00);
            bus(1'h1, ADDR_TSEL, 32'(s));
            setmode(8'h0B);
            wait_hi(adc);
            check("timer a reset", 32'(rsa), 32'(s == 0));
            check("timer b reset", 32'(rsb), 32'(s == 1));
            check("event flag", 32'(flag), 32'h1);
            tick(1);
            check("event pulse", 32'(adc), 32'h0);
            n = 1;
            while (adc !== 1'h1 && n < 300) begin
                @(posedge clk);
                n++;
            end
            check("event spacing", 32'(n), 32'h42);
        end
        for (int m = 8; m < 10; m++) begin
            while (tmb != 8'h00) @(posedge clk);
            setmode(8'(m));
            tick(3);
            check("pin start", 32'(gate.a), 32'(m == 9));
            wait_hi(flag);
            tick(2);
            check("pin on match", 32'(gate.a), 32'(m == 8));
        end
        setmode(8'h02);
        wait_hi(flag);
        tick(2);
        a0 = gate.a;
        tick(256);
        check("toggle", 32'(gate.a), 32'(!a0));
        for (int m = 3; m < 8; m++) begin
            pin <= 1'h0;
            tick(8);
            setmode(8'(m));
            n = 0;
            for (int h = 1; h < 33 && n == 0; h++) begin
                pin <= h[0];
                tick(8);
                if (flag === 1'h1) n = h;
            end
            check("capture edge count", 32'(n), 32'(first[m - 3]));
        end
        // period, then duty, then timer, then mode
        bus(1'h1, ADDR_PERIOD, 32'h3);
        for (int i = 0; i < 4; i++) begin
            bus(1'h1, ADDR_VALUE, 32'(duty[i] >> 2));
            // timer and steering to pin a go on after the first duty, before pwm mode
            if (i == 0) begin
                bus(1'h1, ADDR_TCTRL, 32'h81);
            end
            bus(1'h1, ADDR_CTRL, 32'h0C | 32'((duty[i] % 4) << 4));
            tick(48);
            n = 0;
            repeat (32) begin
                @(posedge clk);
                n += int'(gate.a === 1'h1);
            end
            // period of (3 + 1) * 4 clocks, sampled over two periods
            check("pwm high time", 32'(n), 32'(duty[i] == 0 ? 0 :
                (duty[i] >= 16 ? 32 : 2 * duty[i])));
        end
        final_report();
    end
endmodule // tb_enhanced_ccp_mode_control
